// [design/dbsd_defines.svh]
// Register offsets, field positions and bus answers of the serial DMA block.
`ifndef DBSD_DEFINES_SVH
`define DBSD_DEFINES_SVH
`define DB_OFS_CTRL 8'h00
`define DB_OFS_IRQEN 8'h04
`define DB_OFS_DMAST 8'h08
`define DB_OFS_TXISR 8'h0C
`define DB_OFS_RXISR 8'h10
`define DB_OFS_TXCMD 8'h14
`define DB_OFS_TXEOI 8'h18
`define DB_OFS_TXCUR 8'h1C
`define DB_OFS_TXD 8'h20
`define DB_OFS_RXD 8'h38
`define DB_DESC_STRIDE 8'h0C
`define DB_F_ADDR 8'h00
`define DB_F_CNT 8'h04
`define DB_F_STAT 8'h08
`define DB_ST_OWN 0
`define DB_ST_ENDBUF 1
`define DB_ST_ENDFRM 2
`define DB_ST_BUFIRQ 3
`define DB_ST_STARTBUF 3
`define DB_ST_APPEND 4
`define DB_ST_BUSERR 5
`define DB_DS_NEXTRX 0
`define DB_DS_RXBUSY 1
`define DB_DS_NEXTTX 2
`define DB_DS_TXBUSY 3
`define DB_IS_ENDBUF 0
`define DB_IS_ENDFRM 1
`define DB_IS_EMPTY 2
`define DB_IS_OVERRUN 2
`define DB_IS_BUSERR 3
`define DB_IE_TXDATA 0
`define DB_IE_TXEMPTY 1
`define DB_IE_RX 2
`define DB_CT_DMA 0
`define DB_CT_CHAN 1
`define DB_CT_SYNC 2
`define DB_CMD_TERMAPP 0
`define DB_CMD_ABORT 1
`define DB_EOI_TERM 0
`define DB_RESP_OK 2'h0
`define DB_RESP_ERR 2'h2
`endif

// [design/dbsd_pkg.sv]
// State types of the serial DMA block.
package dbsd_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_READ, TX_PUSH, TX_ERR} dbsd_tx_e;
  typedef enum logic [2:0] {RX_IDLE, RX_RUN, RX_WRITE, RX_NEXT, RX_DROP} dbsd_rx_e;
endpackage

// [design/dbsd_dma.sv]
// Dual-buffer serial DMA engine with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "dbsd_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module dbsd_dma (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic txMemReq,
  output logic [31:0] txMemAddr,
  input wire logic txMemAck,
  input wire logic txMemErr,
  input wire logic [7:0] txMemRdata,
  output logic [7:0] txFifoData,
  output logic txFifoValid,
  output logic txFifoEnd,
  input wire logic txFifoReady,
  output logic txAbort,
  input wire logic [7:0] rxFifoData,
  input wire logic rxFifoValid,
  input wire logic rxFifoLast,
  input wire logic rxFifoFull,
  output logic rxFifoReady,
  output logic rxMemReq,
  output logic [31:0] rxMemAddr,
  output logic [7:0] rxMemWdata,
  input wire logic rxMemAck,
  output logic txDataIrq,
  output logic txEmptyIrq,
  output logic rxIrq
);
  logic [31:0] txAddr_r [2];
  logic [15:0] txCnt_r [2];
  logic [7:0] txSt_r [2];
  logic [15:0] txPos_r [2];
  logic [31:0] rxAddr_r [2];
  logic [15:0] rxCnt_r [2];
  logic [7:0] rxSt_r [2];
  logic [15:0] rxPos_r;
  logic [2:0] ctrl_r;
  logic [2:0] ier_r;
  logic [3:0] txIsr_r;
  logic [2:0] rxIsr_r;
  logic nextTx_r;
  logic nextRx_r;
  logic rxCur_r;
  logic rxBusy_r;
  logic rxLast_r;
  logic termApp_r;
  logic txEnd_r;
  logic txAbort_r;
  logic [7:0] txByte_r;
  logic [7:0] rxByte_r;
  logic [31:0] txCur_r;
  logic [31:0] rxMemAddr_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  dbsd_pkg::dbsd_tx_e txState_r;
  dbsd_pkg::dbsd_rx_e rxState_r;
  logic [3:0] txIsrSet;
  logic [2:0] rxIsrSet;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers for byte lanes and register decoding.
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] old,
    input logic [31:0] nu,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nu[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [7:0] descOfs(
    input logic [7:0] base,
    input logic b,
    input logic [7:0] fld
  );
    return base + (b ? `DB_DESC_STRIDE : 8'h00) + fld;
  endfunction

  function automatic logic [32:0] regValue(input logic [7:0] ofs);
    logic [32:0] v;
    logic [7:0] a;
    a = {ofs[7:2], 2'h0};
    v = 33'h0;
    case (a)
      `DB_OFS_CTRL: v = {1'b1, 29'h0, ctrl_r};
      `DB_OFS_IRQEN: v = {1'b1, 29'h0, ier_r};
      `DB_OFS_DMAST: v = {1'b1, 28'h0, txState_r != dbsd_pkg::TX_IDLE, nextTx_r,
          rxBusy_r, nextRx_r};
      `DB_OFS_TXISR: v = {1'b1, 28'h0, txIsr_r};
      `DB_OFS_RXISR: v = {1'b1, 29'h0, rxIsr_r};
      `DB_OFS_TXCMD: v = {1'b1, 32'h0};
      `DB_OFS_TXEOI: v = {1'b1, 32'h0};
      `DB_OFS_TXCUR: v = {1'b1, txCur_r};
      default: v = 33'h0;
    endcase
    for (int b = 0; b < 2; b++) begin
      if (a == descOfs(`DB_OFS_TXD, 1'(b), `DB_F_ADDR)) v = {1'b1, txAddr_r[b]};
      if (a == descOfs(`DB_OFS_TXD, 1'(b), `DB_F_CNT)) v = {17'h1_0000, txCnt_r[b]};
      if (a == descOfs(`DB_OFS_TXD, 1'(b), `DB_F_STAT)) v = {25'h100_0000, txSt_r[b]};
      if (a == descOfs(`DB_OFS_RXD, 1'(b), `DB_F_ADDR)) v = {1'b1, rxAddr_r[b]};
      if (a == descOfs(`DB_OFS_RXD, 1'(b), `DB_F_CNT)) v = {17'h1_0000, rxCnt_r[b]};
      if (a == descOfs(`DB_OFS_RXD, 1'(b), `DB_F_STAT)) v = {25'h100_0000, rxSt_r[b]};
    end
    return v;
  endfunction

  wire wrEn = ce && awvalid && wvalid && !bvalid_r;
  wire [7:0] wOfs = {awaddr[7:2], 2'h0};
  logic [32:0] wCur;
  logic [31:0] wVal;
  logic [32:0] rCur;

  always_comb begin
    wCur = regValue(wOfs);
    wVal = mergeBytes(wCur[31:0], wdata, wstrb);
    rCur = regValue(araddr);
  end

  function automatic logic wHit(input logic [7:0] ofs);
    return wrEn && (wOfs == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave handshake.
  assign awready = wrEn;
  assign wready = wrEn;
  assign arready = ce && !rvalid_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bvalid_r <= 1'b0;
      bresp_r <= `DB_RESP_OK;
    end else if (ce) begin
      if (wrEn) begin
        bvalid_r <= 1'b1;
        bresp_r <= wCur[32] ? `DB_RESP_OK : `DB_RESP_ERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rvalid_r <= 1'b0;
      rresp_r <= `DB_RESP_OK;
      rdata_r <= 32'h0;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid_r <= 1'b1;
        rresp_r <= rCur[32] ? `DB_RESP_OK : `DB_RESP_ERR;
        rdata_r <= rCur[31:0];
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit decisions.
  wire dmaOn = ctrl_r[`DB_CT_DMA] && ctrl_r[`DB_CT_CHAN];
  wire txOwn = txSt_r[nextTx_r][`DB_ST_OWN];
  wire txApp = !nextTx_r && txSt_r[0][`DB_ST_APPEND];
  wire txHave = txPos_r[nextTx_r] != txCnt_r[nextTx_r];
  wire txIdle = (txState_r == dbsd_pkg::TX_IDLE) && dmaOn;
  wire txStart = txIdle && txOwn && txHave;
  wire txDry = txIdle && txOwn && !txHave;
  wire txAppEnd = txDry && txApp && termApp_r;
  wire txToB = txDry && txApp && !termApp_r && txSt_r[1][`DB_ST_OWN];
  wire txZero = txDry && !txApp;
  wire txEmpty = txIdle && !txStart && !txToB && !txAppEnd && !txZero;
  wire txLastB = !txApp && (txPos_r[nextTx_r] + 16'h0001 == txCnt_r[nextTx_r]);
  wire txPushed = txFifoValid && txFifoReady;
  wire eoiWr = wHit(`DB_OFS_TXEOI);
  wire txInErr = txState_r == dbsd_pkg::TX_ERR;
  wire txTerm = txInErr && eoiWr && wdata[`DB_EOI_TERM];
  wire txRetry = txInErr && eoiWr && !wdata[`DB_EOI_TERM] && txOwn;
  wire txErr = (txState_r == dbsd_pkg::TX_READ) && txMemErr;
  wire txDone = (txPushed && txLastB) || txAppEnd || txZero;

  assign txMemReq = ce && (txState_r == dbsd_pkg::TX_READ);
  assign txMemAddr = txCur_r;
  assign txFifoValid = ce && (txState_r == dbsd_pkg::TX_PUSH);
  assign txFifoData = txByte_r;
  assign txFifoEnd = txEnd_r;
  assign txAbort = txAbort_r;

  always_comb begin
    txIsrSet = 4'h0;
    txIsrSet[`DB_IS_ENDBUF] = txDone && txSt_r[nextTx_r][`DB_ST_BUFIRQ];
    txIsrSet[`DB_IS_ENDFRM] = txIsrSet[`DB_IS_ENDBUF] && txSt_r[nextTx_r][`DB_ST_ENDFRM];
    txIsrSet[`DB_IS_EMPTY] = txEmpty;
    txIsrSet[`DB_IS_BUSERR] = txErr;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit descriptors.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int b = 0; b < 2; b++) begin
        txAddr_r[b] <= 32'h0;
        txCnt_r[b] <= 16'h0;
        txSt_r[b] <= 8'h0;
        txPos_r[b] <= 16'h0;
      end
    end else if (ce) begin
      for (int b = 0; b < 2; b++) begin
        if (!txSt_r[b][`DB_ST_OWN]) begin
          if (wHit(descOfs(`DB_OFS_TXD, 1'(b), `DB_F_ADDR))) begin
            txAddr_r[b] <= wVal;
          end
          if (wHit(descOfs(`DB_OFS_TXD, 1'(b), `DB_F_STAT))) begin
            txSt_r[b] <= wVal[7:0];
          end
        end
        if ((!txSt_r[b][`DB_ST_OWN] || (b == 0 && txSt_r[0][`DB_ST_APPEND]))
            && wHit(descOfs(`DB_OFS_TXD, 1'(b), `DB_F_CNT))) begin
          txCnt_r[b] <= wVal[15:0];
        end
        if (nextTx_r == 1'(b)) begin
          if (txPushed) begin
            txPos_r[b] <= txPos_r[b] + 16'h0001;
          end
          if (txErr) begin
            txSt_r[b][`DB_ST_OWN] <= 1'b0;
            txSt_r[b][`DB_ST_BUSERR] <= 1'b1;
          end
          if (txTerm) begin
            txPos_r[b] <= 16'h0;
          end
          if (txDone) begin
            txPos_r[b] <= 16'h0;
            txSt_r[b][`DB_ST_OWN] <= 1'b0;
            txSt_r[b][`DB_ST_ENDBUF] <= 1'b1;
            txSt_r[b][`DB_ST_APPEND] <= 1'b0;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit engine.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txState_r <= dbsd_pkg::TX_IDLE;
      nextTx_r <= 1'b0;
      txByte_r <= 8'h0;
      txCur_r <= 32'h0;
      txEnd_r <= 1'b0;
    end else if (ce) begin
      if (txDone || txTerm || txToB) begin
        nextTx_r <= !nextTx_r;
      end
      case (txState_r)
        dbsd_pkg::TX_IDLE: begin
          if (txStart) begin
            txCur_r <= txAddr_r[nextTx_r] + {16'h0, txPos_r[nextTx_r]};
            txState_r <= dbsd_pkg::TX_READ;
          end
        end
        dbsd_pkg::TX_READ: begin
          if (txMemErr) begin
            txState_r <= dbsd_pkg::TX_ERR;
          end else if (txMemAck) begin
            txByte_r <= txMemRdata;
            txEnd_r <= txLastB && txSt_r[nextTx_r][`DB_ST_ENDFRM] && ctrl_r[`DB_CT_SYNC];
            txState_r <= dbsd_pkg::TX_PUSH;
          end
        end
        dbsd_pkg::TX_PUSH: begin
          if (txFifoReady) begin
            txState_r <= dbsd_pkg::TX_IDLE;
          end
        end
        dbsd_pkg::TX_ERR: begin
          if (txTerm) begin
            txState_r <= dbsd_pkg::TX_IDLE;
          end else if (txRetry) begin
            txState_r <= dbsd_pkg::TX_READ;
          end
        end
        default: txState_r <= dbsd_pkg::TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control, commands and status.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= 3'h0;
      ier_r <= 3'h0;
      termApp_r <= 1'b0;
      txAbort_r <= 1'b0;
      txIsr_r <= 4'h0;
      rxIsr_r <= 3'h0;
    end else if (ce) begin
      if (wHit(`DB_OFS_CTRL)) begin
        ctrl_r <= wVal[2:0];
      end
      if (wHit(`DB_OFS_IRQEN)) begin
        ier_r <= wVal[2:0];
      end
      if (wHit(`DB_OFS_TXCMD) && wVal[`DB_CMD_TERMAPP]) begin
        termApp_r <= 1'b1;
      end else if (txAppEnd) begin
        termApp_r <= 1'b0;
      end
      txAbort_r <= wHit(`DB_OFS_TXCMD) && wVal[`DB_CMD_ABORT];
      txIsr_r <= (eoiWr ? 4'h0 : txIsr_r) | txIsrSet;
      rxIsr_r <= (rxIsr_r & ~((wHit(`DB_OFS_RXISR) && wstrb[0]) ? wdata[2:0] : 3'h0))
          | rxIsrSet;
    end
  end

  assign txDataIrq = ier_r[`DB_IE_TXDATA]
      && (txIsr_r[`DB_IS_ENDBUF] || txIsr_r[`DB_IS_BUSERR]);
  assign txEmptyIrq = ier_r[`DB_IE_TXEMPTY] && txIsr_r[`DB_IS_EMPTY];
  assign rxIrq = ier_r[`DB_IE_RX] && (rxIsr_r != 3'h0);

  ////////////////////////////////////////////////////////////////////////////////
  // Receive decisions.
  wire rxNextOwn = rxSt_r[nextRx_r][`DB_ST_OWN];
  wire rxWait = ((rxState_r == dbsd_pkg::RX_IDLE) && rxFifoValid)
      || (rxState_r == dbsd_pkg::RX_NEXT);
  wire rxBegin = dmaOn && rxWait && rxNextOwn;
  wire rxOvr = dmaOn && rxWait && !rxNextOwn && rxFifoFull;
  wire rxAck = (rxState_r == dbsd_pkg::RX_WRITE) && rxMemAck;
  wire rxEnd = rxAck && rxLast_r;
  wire rxFill = rxAck && !rxLast_r && (rxPos_r + 16'h0001 == rxCnt_r[rxCur_r]);

  assign rxFifoReady = ce && ((rxState_r == dbsd_pkg::RX_RUN)
      || (rxState_r == dbsd_pkg::RX_DROP));
  assign rxMemReq = ce && (rxState_r == dbsd_pkg::RX_WRITE);
  assign rxMemAddr = rxMemAddr_r;
  assign rxMemWdata = rxByte_r;

  always_comb begin
    rxIsrSet = 3'h0;
    rxIsrSet[`DB_IS_ENDBUF] = rxFill || rxEnd;
    rxIsrSet[`DB_IS_ENDFRM] = rxEnd;
    rxIsrSet[`DB_IS_OVERRUN] = rxOvr;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive descriptors.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int b = 0; b < 2; b++) begin
        rxAddr_r[b] <= 32'h0;
        rxCnt_r[b] <= 16'h0;
        rxSt_r[b] <= 8'h0;
      end
    end else if (ce) begin
      for (int b = 0; b < 2; b++) begin
        if (!rxSt_r[b][`DB_ST_OWN]) begin
          if (wHit(descOfs(`DB_OFS_RXD, 1'(b), `DB_F_ADDR))) begin
            rxAddr_r[b] <= wVal;
          end
          if (wHit(descOfs(`DB_OFS_RXD, 1'(b), `DB_F_CNT))) begin
            rxCnt_r[b] <= wVal[15:0];
          end
          if (wHit(descOfs(`DB_OFS_RXD, 1'(b), `DB_F_STAT))) begin
            rxSt_r[b] <= wVal[7:0];
          end
        end
        if (rxFill && rxCur_r == 1'(b)) begin
          rxSt_r[b][`DB_ST_OWN] <= 1'b0;
          rxSt_r[b][`DB_ST_ENDBUF] <= 1'b1;
          rxSt_r[b][`DB_ST_STARTBUF] <= 1'b1;
          rxSt_r[b][`DB_ST_ENDFRM] <= 1'b0;
        end
        if (rxEnd && rxCur_r == 1'(b)) begin
          rxCnt_r[b] <= rxPos_r + 16'h0001;
          rxSt_r[b][`DB_ST_OWN] <= 1'b0;
          rxSt_r[b][`DB_ST_ENDBUF] <= 1'b1;
          rxSt_r[b][`DB_ST_ENDFRM] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive engine.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxState_r <= dbsd_pkg::RX_IDLE;
      nextRx_r <= 1'b0;
      rxCur_r <= 1'b0;
      rxBusy_r <= 1'b0;
      rxPos_r <= 16'h0;
      rxByte_r <= 8'h0;
      rxLast_r <= 1'b0;
      rxMemAddr_r <= 32'h0;
    end else if (ce) begin
      case (rxState_r)
        dbsd_pkg::RX_IDLE, dbsd_pkg::RX_NEXT: begin
          if (rxBegin) begin
            rxCur_r <= nextRx_r;
            nextRx_r <= !nextRx_r;
            rxPos_r <= 16'h0;
            rxBusy_r <= 1'b1;
            rxState_r <= dbsd_pkg::RX_RUN;
          end else if (rxOvr) begin
            rxBusy_r <= 1'b1;
            rxState_r <= dbsd_pkg::RX_DROP;
          end
        end
        dbsd_pkg::RX_RUN: begin
          if (rxFifoValid) begin
            rxByte_r <= rxFifoData;
            rxLast_r <= rxFifoLast;
            rxMemAddr_r <= rxAddr_r[rxCur_r] + {16'h0, rxPos_r};
            rxState_r <= dbsd_pkg::RX_WRITE;
          end
        end
        dbsd_pkg::RX_WRITE: begin
          if (rxMemAck) begin
            rxPos_r <= rxPos_r + 16'h0001;
            if (rxEnd) begin
              rxBusy_r <= 1'b0;
              rxState_r <= dbsd_pkg::RX_IDLE;
            end else if (rxFill) begin
              rxState_r <= dbsd_pkg::RX_NEXT;
            end else begin
              rxState_r <= dbsd_pkg::RX_RUN;
            end
          end
        end
        dbsd_pkg::RX_DROP: begin
          if (rxFifoValid && rxFifoLast) begin
            rxBusy_r <= 1'b0;
            rxState_r <= dbsd_pkg::RX_IDLE;
          end
        end
        default: rxState_r <= dbsd_pkg::RX_IDLE;
      endcase
    end
  end
endmodule

// [test/dbsd_dma_chk.sv]
// Port assertions of the serial DMA block.
`timescale 1ns/1ps
//////////////////////////////
module dbsd_dma_chk (
  input logic clk,
  input logic rst_b,
  input logic ce,
  input logic awvalid,
  input logic awready,
  input logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  input logic bready,
  input logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic rvalid,
  input logic rready,
  input logic txMemReq,
  input logic [31:0] txMemAddr,
  input logic txMemAck,
  input logic txMemErr,
  input logic [7:0] txMemRdata,
  input logic [7:0] txFifoData,
  input logic txFifoValid,
  input logic txFifoReady
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b || !ce);
  sequence s_fetch; txMemReq && txMemAck; endsequence
  sequence s_push; txFifoValid && txFifoData == $past(txMemRdata); endsequence
  property p_wr; awvalid && wvalid && awready && wready |=> bvalid; endproperty
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_rd; arvalid && arready |=> rvalid; endproperty
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_req; txMemReq && !txMemAck && !txMemErr |=> txMemReq && $stable(txMemAddr);
  endproperty
  property p_push; s_fetch |=> s_push; endproperty
  property p_fhold; txFifoValid && !txFifoReady |=> txFifoValid && $stable(txFifoData);
  endproperty
  property p_merr; txMemReq && txMemErr |=> $stable(txMemAddr); endproperty
  a_wr: assert property (p_wr) else $error("write not answered");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_rd: assert property (p_rd) else $error("read not answered");
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  a_req: assert property (p_req) else $error("fetch request changed");
  a_push: assert property (p_push) else $error("fetched byte not pushed");
  a_fhold: assert property (p_fhold) else $error("fifo byte changed");
  a_merr: assert property (p_merr) else $error("fault address lost");
endmodule
bind dbsd_dma dbsd_dma_chk i_dbsd_dma_chk (.clk, .rst_b, .ce, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .txMemReq,
  .txMemAddr, .txMemAck, .txMemErr, .txMemRdata, .txFifoData, .txFifoValid, .txFifoReady);

// [test/dbsd_mem_model.sv]
// Memory-side model that answers the byte reads and writes of the DMA block.
`timescale 1ns/1ps
//////////////////////////////
module dbsd_mem_model (
  input logic clk,
  input logic rst_b,
  input logic txMemReq,
  input logic [31:0] txMemAddr,
  output logic txMemAck,
  output logic txMemErr,
  output logic [7:0] txMemRdata,
  input logic rxMemReq,
  input logic [31:0] rxMemAddr,
  input logic [7:0] rxMemWdata,
  output logic rxMemAck,
  input logic errEn,
  input logic [31:0] errAddr,
  input logic slow
);
  logic [1:0] waitCnt_r;
  logic [7:0] rxMem [0:4095];
  always_ff @(posedge clk) begin
    txMemAck <= 1'b0;
    txMemErr <= 1'b0;
    txMemRdata <= ~txMemRdata;
    if (!rst_b) begin
      waitCnt_r <= 2'h0;
      txMemRdata <= 8'h00;
    end else if (txMemReq && !txMemAck && !txMemErr) begin
      if (slow && waitCnt_r != 2'h3) begin
        waitCnt_r <= waitCnt_r + 2'h1;
      end else begin
        waitCnt_r <= 2'h0;
        txMemErr <= errEn && txMemAddr == errAddr;
        txMemAck <= !(errEn && txMemAddr == errAddr);
        txMemRdata <= txMemAddr[7:0] ^ 8'hA5;
      end
    end
  end
  always_ff @(posedge clk) begin
    rxMemAck <= rst_b && rxMemReq && !rxMemAck;
    if (rxMemReq && !rxMemAck) begin
      rxMem[rxMemAddr[11:0]] <= rxMemWdata;
    end
  end
endmodule

// [test/dbsd_dma_tb.sv]
// Self-checking bench of the serial DMA block.
`timescale 1ns/1ps
module dbsd_dma_tb;
  localparam logic [31:0] allBits = 32'hFFFFFFFF;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, rxFifoFull = 1'b0, errEn = 1'b0, slow = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic txFifoReady = 1'b0, rxFifoValid = 1'b0, rxFifoLast = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, rxFifoData = 8'h00, txMemRdata, txFifoData;
  logic [7:0] rxMemWdata;
  logic [31:0] wdata = 32'h0, errAddr = 32'h0, d, rdata, txMemAddr, rxMemAddr;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, txMemReq, txMemAck, txMemErr, txFifoValid;
  logic txFifoEnd, txAbort, rxFifoReady, rxMemReq, rxMemAck, txDataIrq, txEmptyIrq, rxIrq;
  logic [7:0] seen[$];
  int ends = 0, aborts = 0, bad_count = 0, comparisons = 0;
  dbsd_dma i_dbsd_dma (.clk, .rst_b, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .txMemReq, .txMemAddr, .txMemAck, .txMemErr, .txMemRdata, .txFifoData,
    .txFifoValid, .txFifoEnd, .txFifoReady, .txAbort, .rxFifoData, .rxFifoValid, .rxFifoLast,
    .rxFifoFull, .rxFifoReady, .rxMemReq, .rxMemAddr, .rxMemWdata, .rxMemAck, .txDataIrq,
    .txEmptyIrq, .rxIrq);
  dbsd_mem_model i_dbsd_mem_model (.clk, .rst_b, .txMemReq, .txMemAddr, .txMemAck, .txMemErr,
    .txMemRdata, .rxMemReq, .rxMemAddr, .rxMemWdata, .rxMemAck, .errEn, .errAddr, .slow);
  always #10 clk = ~clk;
  always @(posedge clk) begin
    txFifoReady <= ~txFifoReady;
    aborts <= aborts + int'(txAbort);
    if (txFifoValid && txFifoReady) begin
      seen.push_back(txFifoData);
      ends <= ends + int'(txFifoEnd);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    resp = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  task automatic desc(input logic [7:0] b, input logic [31:0] ad, input logic [31:0] c,
      input logic [31:0] s);
    wr(b, ad);
    wr(b + 8'h04, c);
    wr(b + 8'h08, s);
  endtask
  task automatic waitClr(input logic [7:0] a);
    d = 32'h1;
    while (d[0] !== 1'b0) rd(a);
  endtask
  task automatic feed(input int n);
    rxFifoValid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      rxFifoData <= 8'h30 + 8'(i);
      rxFifoLast <= (i == n - 1);
      do @(posedge clk); while (!rxFifoReady);
    end
    rxFifoValid <= 1'b0;
  endtask
  task automatic t_reset;
    rc(8'h08, allBits, 32'h0);
    rc(8'h28, allBits, 32'h0);
    rc(8'h50, allBits, 32'h0);
    chk({30'h0, resp}, 32'h2);
    $display("reset test done");
  endtask
  task automatic t_chain;
    desc(8'h20, 32'h100, 32'h3, 32'h9);
    wr(8'h20, 32'h999);
    rc(8'h20, allBits, 32'h100);
    desc(8'h2C, 32'h180, 32'h2, 32'hD);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h7);
    waitClr(8'h34);
    chk(seen.size(), 32'h5);
    for (int i = 0; i < 5; i++) chk(seen[i], 32'((i < 3 ? i : 32'h7D + i) ^ 32'hA5));
    chk(ends, 32'h1);
    rc(8'h28, allBits, 32'hA);
    rc(8'h34, allBits, 32'hE);
    rc(8'h08, 32'h4, 32'h0);
    rc(8'h0C, 32'h3, 32'h3);
    chk(txDataIrq, 32'h1);
    $display("chain test done");
  endtask
  task automatic t_err;
    errAddr <= 32'h201;
    errEn <= 1'b1;
    slow <= 1'b1;
    desc(8'h20, 32'h200, 32'h2, 32'h1);
    waitClr(8'h28);
    chk(d & 32'h20, 32'h20);
    rc(8'h1C, allBits, 32'h201);
    rc(8'h0C, 32'h8, 32'h8);
    errEn <= 1'b0;
    wr(8'h28, 32'h1);
    wr(8'h18, 32'h0);
    waitClr(8'h28);
    chk(seen.size(), 32'h7);
    chk(seen[6], 32'hA4);
    $display("bus error test done");
  endtask
  task automatic t_rx;
    desc(8'h38, 32'h300, 32'h4, 32'h1);
    desc(8'h44, 32'h400, 32'hA, 32'h1);
    feed(6);
    waitClr(8'h4C);
    rc(8'h3C, allBits, 32'h4);
    rc(8'h40, allBits, 32'hA);
    rc(8'h48, allBits, 32'h2);
    rc(8'h4C, allBits, 32'h6);
    rc(8'h08, 32'h1, 32'h0);
    rc(8'h10, 32'h3, 32'h3);
    for (int i = 0; i < 6; i++)
      chk(i_dbsd_mem_model.rxMem[i < 4 ? 32'h300 + i : 32'h3FC + i], 32'h30 + i);
    $display("receive test done");
  endtask
  task automatic t_app;
    logic [47:0] ex = 48'h25A5A42524A7;
    chk(txEmptyIrq, 32'h0);
    wr(8'h04, 32'h3);
    chk(txEmptyIrq, 32'h1);
    desc(8'h20, 32'h100, 32'h0, 32'h11);
    desc(8'h2C, 32'h180, 32'h1, 32'h1);
    waitClr(8'h34);
    wr(8'h24, 32'h2);
    desc(8'h2C, 32'h180, 32'h2, 32'h1);
    waitClr(8'h34);
    wr(8'h24, 32'h3);
    wr(8'h14, 32'h1);
    waitClr(8'h28);
    chk(seen.size(), 32'hD);
    for (int i = 0; i < 6; i++) chk(seen[7 + i], ex[47 - 8 * i -: 8]);
    rc(8'h28, allBits, 32'h2);
    chk(ends, 32'h1);
    $display("append test done");
  endtask
  task automatic t_term;
    errAddr <= 32'h180;
    errEn <= 1'b1;
    desc(8'h2C, 32'h180, 32'h2, 32'h1);
    waitClr(8'h34);
    errEn <= 1'b0;
    rc(8'h08, 32'h4, 32'h4);
    wr(8'h14, 32'h2);
    chk(aborts, 32'h1);
    wr(8'h18, 32'h1);
    rc(8'h08, 32'h4, 32'h0);
    rc(8'h34, allBits, 32'h20);
    chk(seen.size(), 32'hD);
    $display("terminate test done");
  endtask
  task automatic t_ovr;
    wr(8'h04, 32'h7);
    wr(8'h10, 32'h7);
    chk(rxIrq, 32'h0);
    rxFifoFull <= 1'b1;
    feed(3);
    rxFifoFull <= 1'b0;
    rc(8'h10, allBits, 32'h4);
    chk(rxIrq, 32'h1);
    rc(8'h08, 32'h3, 32'h0);
    $display("overrun test done");
  endtask
  task automatic results;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_chain;
    t_err;
    t_rx;
    t_app;
    t_term;
    t_ovr;
    results;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    results;
  end
endmodule
